// ---- logic/vintc_top.sv ----
// Vectored interrupt controller: classification, priority and vector select
//
// Behaviour
// - Each request line is classed fast, vectored or plain normal by live settings.
// - Fast class ranks highest; all fast requests OR into one fast output.
// - A status word shows each fast-class source now requesting.
// - Sixteen slots take any channel; slot 0 highest, slot 15 lowest.
// - Vectored requests rank below fast, above non-vectored; non-vectored lowest.
// - Normal output is the OR of all vectored and non-vectored requests.
// - Vector read gives winning slot address, else the shared default address.
// - A status word shows which normal-class requests are active.
// - One request line per peripheral, high while any of its flags is set.
// - Channel 1 has no hardware source; only software raises it.
// - Fixed channel map for watchdog, debug, timers, serial, PWM, I2C, SSP, PLL.
// - Timer lines combine four match and four capture flags each.
// - Serial lines combine line, holding, data and timeout flags; port 1 adds modem.
// - PWM line combines its seven match flags.
// - Real-time clock line combines increment and alarm flags.
// - External inputs 0 to 3 on channels 14 to 17, converter on 18.
`timescale 1ns/1ps

module vintc_top
  import vintc_pkg::*;
(
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        reset_n_i,
  // Watchdog and debug channel
  input  wire logic                        watchdog_flag_i,
  input  wire logic                        debug_comm_receive_i,
  input  wire logic                        debug_comm_transmit_i,
  // Timers
  input  wire logic [3:0]                  timer0_match_flag_i,
  input  wire logic [3:0]                  timer0_capture_flag_i,
  input  wire logic [3:0]                  timer1_match_flag_i,
  input  wire logic [3:0]                  timer1_capture_flag_i,
  // Serial port 0
  input  wire logic                        uart0_rx_line_status_flag_i,
  input  wire logic                        uart0_tx_holding_empty_flag_i,
  input  wire logic                        uart0_rx_data_available_flag_i,
  input  wire logic                        uart0_char_timeout_flag_i,
  // Serial port 1
  input  wire logic                        uart1_rx_line_status_flag_i,
  input  wire logic                        uart1_tx_holding_empty_flag_i,
  input  wire logic                        uart1_rx_data_available_flag_i,
  input  wire logic                        uart1_char_timeout_flag_i,
  input  wire logic                        uart1_modem_status_flag_i,
  // PWM and I2C
  input  wire logic [6:0]                  pwm_match_flag_i,
  input  wire logic                        i2c_state_change_flag_i,
  // Synchronous serial ports
  input  wire logic                        ssp0_serial_transfer_done_flag_i,
  input  wire logic                        ssp0_mode_fault_flag_i,
  input  wire logic                        ssp1_serial_transfer_done_flag_i,
  input  wire logic                        ssp1_mode_fault_flag_i,
  // PLL and real-time clock
  input  wire logic                        pll_locked_flag_i,
  input  wire logic                        rtc_increment_flag_i,
  input  wire logic                        rtc_alarm_flag_i,
  // External interrupts and converter
  input  wire logic                        external_irq_0_i,
  input  wire logic                        external_irq_1_i,
  input  wire logic                        external_irq_2_i,
  input  wire logic                        external_irq_3_i,
  input  wire logic                        adc_done_flag_i,
  // Software raised requests
  input  wire logic [NUM_CH-1:0]           soft_set_i,
  input  wire logic [NUM_CH-1:0]           soft_clear_i,
  // Classification
  input  wire logic [NUM_CH-1:0]           int_enable_i,
  input  wire logic [NUM_CH-1:0]           fast_select_i,
  // Vector slots
  input  wire logic [NUM_SLOTS-1:0]        slot_enable_i,
  input  wire logic [NUM_SLOTS*CH_W-1:0]   slot_channel_i,
  input  wire logic [NUM_SLOTS*ADDR_W-1:0] slot_addr_i,
  input  wire logic [ADDR_W-1:0]           default_addr_i,
  // Vector read strobe
  input  wire logic                        vector_read_i,
  // Processor requests
  output logic                             fast_request_o,
  output logic                             normal_request_o,
  // Status words
  output logic [NUM_CH-1:0]                raw_status_o,
  output logic [NUM_CH-1:0]                fast_status_o,
  output logic [NUM_CH-1:0]                normal_status_o,
  output logic [NUM_CH-1:0]                soft_pending_o,
  output logic [NUM_SLOTS-1:0]             slot_status_o,
  // Vector
  output logic [ADDR_W-1:0]                vector_addr_o,
  output logic                             vector_hit_o,
  output logic [SLOT_W-1:0]                vector_slot_o,
  output logic [ADDR_W-1:0]                vector_data_o,
  output logic                             vector_valid_o
);

  // ==========================================================
  // Internal signals
  logic [NUM_CH-1:0]    hw_req;
  logic [NUM_CH-1:0]    soft_q;
  logic [NUM_CH-1:0]    soft_d;
  logic [NUM_CH-1:0]    any_req;
  logic [NUM_CH-1:0]    live_req;
  logic [NUM_CH-1:0]    fast_req;
  logic [NUM_CH-1:0]    normal_req;
  logic                 arb_hit;
  logic [SLOT_W-1:0]    arb_index;
  logic [NUM_SLOTS-1:0] arb_active;
  logic [ADDR_W-1:0]    vector_d;
  logic                 timer0_line;
  logic                 timer1_line;
  logic                 uart0_line;
  logic                 uart1_line;
  logic                 pwm_line;
  logic                 ssp0_line;
  logic                 ssp1_line;
  logic                 rtc_line;

  // ==========================================================
  // One request line per peripheral, high while any of its flags is set
  assign timer0_line = |{timer0_match_flag_i, timer0_capture_flag_i};
  assign timer1_line = |{timer1_match_flag_i, timer1_capture_flag_i};
  assign uart0_line  = uart0_rx_line_status_flag_i
                     | uart0_tx_holding_empty_flag_i
                     | uart0_rx_data_available_flag_i
                     | uart0_char_timeout_flag_i;
  assign uart1_line  = uart1_rx_line_status_flag_i
                     | uart1_tx_holding_empty_flag_i
                     | uart1_rx_data_available_flag_i
                     | uart1_char_timeout_flag_i
                     | uart1_modem_status_flag_i;
  assign pwm_line    = |pwm_match_flag_i;
  assign ssp0_line   = ssp0_serial_transfer_done_flag_i | ssp0_mode_fault_flag_i;
  assign ssp1_line   = ssp1_serial_transfer_done_flag_i | ssp1_mode_fault_flag_i;
  assign rtc_line    = rtc_increment_flag_i | rtc_alarm_flag_i;

  // ==========================================================
  // Peripheral lines onto channels
  always_comb begin
    hw_req               = RST_CH;
    hw_req[CH_WATCHDOG]  = watchdog_flag_i;
    hw_req[CH_SOFT_ONLY] = 1'b0;
    hw_req[CH_DBG_RX]    = debug_comm_receive_i;
    hw_req[CH_DBG_TX]    = debug_comm_transmit_i;
    hw_req[CH_TIMER0]    = timer0_line;
    hw_req[CH_TIMER1]    = timer1_line;
    hw_req[CH_UART0]     = uart0_line;
    hw_req[CH_UART1]     = uart1_line;
    hw_req[CH_PWM]       = pwm_line;
    hw_req[CH_I2C]       = i2c_state_change_flag_i;
    hw_req[CH_SSP0]      = ssp0_line;
    hw_req[CH_SSP1]      = ssp1_line;
    hw_req[CH_PLL]       = pll_locked_flag_i;
    hw_req[CH_RTC]       = rtc_line;
    hw_req[CH_EXT0]      = external_irq_0_i;
    hw_req[CH_EXT1]      = external_irq_1_i;
    hw_req[CH_EXT2]      = external_irq_2_i;
    hw_req[CH_EXT3]      = external_irq_3_i;
    hw_req[CH_ADC]       = adc_done_flag_i;
  end

  // ==========================================================
  // Software raised requests, set wins over clear
  assign soft_d = soft_set_i | (soft_q & ~soft_clear_i);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_q <= RST_CH;
    end else begin
      soft_q <= soft_d;
    end
  end

  // ==========================================================
  // Classification
  assign any_req    = hw_req | soft_q;
  assign live_req   = any_req & int_enable_i;
  assign fast_req   = live_req & fast_select_i;
  assign normal_req = live_req & ~fast_select_i;

  // ==========================================================
  // Vectored slot selection
  vintc_slot_arb u_slot_arb (
    .normal_req_i   (normal_req),
    .slot_enable_i  (slot_enable_i),
    .slot_channel_i (slot_channel_i),
    .slot_hit_o     (arb_hit),
    .slot_index_o   (arb_index),
    .slot_active_o  (arb_active)
  );

  // Winning slot address, else the shared default
  always_comb begin
    if (arb_hit) begin
      vector_d = slot_addr_i[arb_index*ADDR_W +: ADDR_W];
    end else begin
      vector_d = default_addr_i;
    end
  end

  // ==========================================================
  // Processor requests
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fast_request_o <= 1'b0;
    end else begin
      fast_request_o <= |fast_req;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      normal_request_o <= 1'b0;
    end else begin
      normal_request_o <= |normal_req;
    end
  end

  // ==========================================================
  // Status words
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_status_o <= RST_CH;
    end else begin
      raw_status_o <= any_req;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fast_status_o <= RST_CH;
    end else begin
      fast_status_o <= fast_req;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      normal_status_o <= RST_CH;
    end else begin
      normal_status_o <= normal_req;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_pending_o <= RST_CH;
    end else begin
      soft_pending_o <= soft_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_status_o <= RST_SLOTS;
    end else begin
      slot_status_o <= arb_active;
    end
  end

  // ==========================================================
  // Vector address, fast class served apart through its own output
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_addr_o <= RST_ADDR;
    end else begin
      vector_addr_o <= vector_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_hit_o <= 1'b0;
    end else begin
      vector_hit_o <= arb_hit;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_slot_o <= RST_SLOT;
    end else begin
      vector_slot_o <= arb_index;
    end
  end

  // ==========================================================
  // Vector read capture
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_valid_o <= 1'b0;
    end else begin
      vector_valid_o <= vector_read_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_data_o <= RST_ADDR;
    end else if (vector_read_i) begin
      vector_data_o <= vector_d;
    end
  end

endmodule // vintc_top

// ---- shared/vintc_pkg.sv ----
// Constants shared by the vectored interrupt controller
package vintc_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH    = 19;
  localparam int NUM_SLOTS = 16;
  localparam int CH_W      = 5;
  localparam int SLOT_W    = 4;
  localparam int ADDR_W    = 32;
  localparam int CH_SPAN   = 32;

  // ==========================================================
  // Channel numbers
  localparam int CH_WATCHDOG   = 0;
  localparam int CH_SOFT_ONLY  = 1;
  localparam int CH_DBG_RX     = 2;
  localparam int CH_DBG_TX     = 3;
  localparam int CH_TIMER0     = 4;
  localparam int CH_TIMER1     = 5;
  localparam int CH_UART0      = 6;
  localparam int CH_UART1      = 7;
  localparam int CH_PWM        = 8;
  localparam int CH_I2C        = 9;
  localparam int CH_SSP0       = 10;
  localparam int CH_SSP1       = 11;
  localparam int CH_PLL        = 12;
  localparam int CH_RTC        = 13;
  localparam int CH_EXT0       = 14;
  localparam int CH_EXT1       = 15;
  localparam int CH_EXT2       = 16;
  localparam int CH_EXT3       = 17;
  localparam int CH_ADC        = 18;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0]    RST_ADDR  = 32'h0000_0000;
  localparam logic [NUM_CH-1:0]    RST_CH    = 19'h0_0000;
  localparam logic [NUM_SLOTS-1:0] RST_SLOTS = 16'h0000;
  localparam logic [SLOT_W-1:0]    RST_SLOT  = 4'h0;

endpackage

// ---- logic/vintc_slot_arb.sv ----
// Slot match and fixed-priority selection of the vectored slots
`timescale 1ns/1ps

module vintc_slot_arb
  import vintc_pkg::*;
(
  // Normal-class requests, enabled only
  input  wire logic [NUM_CH-1:0]         normal_req_i,
  // Slot setup
  input  wire logic [NUM_SLOTS-1:0]      slot_enable_i,
  input  wire logic [NUM_SLOTS*CH_W-1:0] slot_channel_i,
  // Result
  output logic                           slot_hit_o,
  output logic [SLOT_W-1:0]              slot_index_o,
  output logic [NUM_SLOTS-1:0]           slot_active_o
);

  logic [CH_SPAN-1:0] req_ext;

  assign req_ext = {{(CH_SPAN-NUM_CH){1'b0}}, normal_req_i};

  // ==========================================================
  // Per-slot match, any channel into any slot
  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
      logic [CH_W-1:0] chan;
      assign chan             = slot_channel_i[s*CH_W +: CH_W];
      assign slot_active_o[s] = slot_enable_i[s] & req_ext[chan];
    end
  endgenerate

  // ==========================================================
  // Lowest slot number wins
  always_comb begin
    slot_hit_o   = 1'b0;
    slot_index_o = RST_SLOT;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (slot_active_o[i]) begin
        slot_hit_o   = 1'b1;
        slot_index_o = SLOT_W'(i);
      end
    end
  end

endmodule // vintc_slot_arb

// ---- tb/vintc_monitor.sv ----
// Port checks for the vectored interrupt controller
`timescale 1ns/1ps

module vintc_monitor
  import vintc_pkg::*;
(
  // Clock, reset and settings
  input wire logic                        core_clk_i,
  input wire logic                        reset_n_i,
  input wire logic [NUM_CH-1:0]           int_enable_i,
  input wire logic [NUM_CH-1:0]           fast_select_i,
  input wire logic [NUM_SLOTS*ADDR_W-1:0] slot_addr_i,
  input wire logic [ADDR_W-1:0]           default_addr_i,
  input wire logic                        vector_read_i,
  // Design outputs
  input wire logic                        fast_request_o,
  input wire logic                        normal_request_o,
  input wire logic [NUM_CH-1:0]           raw_status_o,
  input wire logic [NUM_CH-1:0]           fast_status_o,
  input wire logic [NUM_CH-1:0]           normal_status_o,
  input wire logic [NUM_SLOTS-1:0]        slot_status_o,
  input wire logic [ADDR_W-1:0]           vector_addr_o,
  input wire logic                        vector_hit_o,
  input wire logic [SLOT_W-1:0]           vector_slot_o,
  input wire logic [ADDR_W-1:0]           vector_data_o,
  input wire logic                        vector_valid_o
);
  // ==========================================================
  // Armed from the second edge after reset
  logic up_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // Assertions
  a_fast_combine: assert property (fast_request_o == |fast_status_o)
    else $error("fast request differs from fast status");
  a_normal_combine: assert property (normal_request_o == |normal_status_o)
    else $error("normal request differs from normal status");
  a_fast_class: assert property (up_q |->
    fast_status_o == (raw_status_o & $past(int_enable_i & fast_select_i)))
    else $error("fast status wrong");
  a_normal_class: assert property (up_q |->
    normal_status_o == (raw_status_o & $past(int_enable_i & ~fast_select_i)))
    else $error("normal status wrong");
  a_slot_winner: assert property ((vector_hit_o == |slot_status_o) && (!vector_hit_o ||
    slot_status_o[vector_slot_o] && (slot_status_o & ((16'h1 << vector_slot_o) - 16'h1)) == '0))
    else $error("winning slot wrong");
  a_vector_slot: assert property (up_q && vector_hit_o |->
    vector_addr_o == ADDR_W'($past(slot_addr_i) >> (vector_slot_o * ADDR_W)))
    else $error("slot vector address wrong");
  a_vector_default: assert property (up_q && !vector_hit_o |->
    vector_addr_o == $past(default_addr_i)) else $error("default address wrong");
  a_read_capture: assert property (vector_read_i |=>
    vector_valid_o && vector_data_o == vector_addr_o) else $error("vector capture wrong");
endmodule // vintc_monitor

// ---- tb/vintc_core_model.sv ----
// Processor side model that fetches the vector while a normal request stands
`timescale 1ns/1ps

module vintc_core_model
  import vintc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // Controller outputs
  input  wire logic              fast_request_i,
  input  wire logic              normal_request_i,
  input  wire logic              vector_valid_i,
  input  wire logic [ADDR_W-1:0] vector_data_i,
  // Vector fetch
  output logic                   vector_read_o,
  output logic [ADDR_W-1:0]      last_vector_o
);
  // Fast class is served first, so no fetch while it stands
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) vector_read_o <= 1'b0;
    else vector_read_o <= normal_request_i & ~fast_request_i & ~vector_read_o;
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) last_vector_o <= '0;
    else if (vector_valid_i) last_vector_o <= vector_data_i;
  end
endmodule // vintc_core_model

// ---- tb/vintc_top_test.sv ----
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps

module vintc_top_test
  import vintc_pkg::*;
;
  // ==========================================================
  // Signals
  logic [NUM_CH-1:0] soft_set_i, soft_clear_i, int_enable_i, fast_select_i;
  logic [NUM_CH-1:0] raw_status_o, fast_status_o, normal_status_o, soft_pending_o;
  logic [NUM_SLOTS-1:0] slot_enable_i, slot_status_o;
  logic [NUM_SLOTS*CH_W-1:0] slot_channel_i;
  logic [NUM_SLOTS*ADDR_W-1:0] slot_addr_i;
  logic [ADDR_W-1:0] default_addr_i, vector_addr_o, vector_data_o, last_vector;
  logic [SLOT_W-1:0] vector_slot_o;
  logic core_clk_i, reset_n_i, vector_read_i, fast_request_o, normal_request_o;
  logic vector_hit_o, vector_valid_o;
  logic [47:0] flags;
  int fail_count = 0, n_compared = 0, cycles = 0;
  wire       watchdog_flag_i = flags[0], debug_comm_receive_i = flags[1];
  wire       debug_comm_transmit_i = flags[2];
  wire [3:0] timer0_match_flag_i = flags[6:3], timer0_capture_flag_i = flags[10:7];
  wire [3:0] timer1_match_flag_i = flags[14:11], timer1_capture_flag_i = flags[18:15];
  wire       uart0_rx_line_status_flag_i = flags[19], uart0_tx_holding_empty_flag_i = flags[20];
  wire       uart0_rx_data_available_flag_i = flags[21], uart0_char_timeout_flag_i = flags[22];
  wire       uart1_rx_line_status_flag_i = flags[23], uart1_tx_holding_empty_flag_i = flags[24];
  wire       uart1_rx_data_available_flag_i = flags[25], uart1_char_timeout_flag_i = flags[26];
  wire       uart1_modem_status_flag_i = flags[27];
  wire [6:0] pwm_match_flag_i = flags[34:28];
  wire       i2c_state_change_flag_i = flags[35], ssp0_serial_transfer_done_flag_i = flags[36];
  wire       ssp0_mode_fault_flag_i = flags[37], ssp1_serial_transfer_done_flag_i = flags[38];
  wire       ssp1_mode_fault_flag_i = flags[39], pll_locked_flag_i = flags[40];
  wire       rtc_increment_flag_i = flags[41], rtc_alarm_flag_i = flags[42];
  wire       external_irq_0_i = flags[43], external_irq_1_i = flags[44];
  wire       external_irq_2_i = flags[45], external_irq_3_i = flags[46];
  wire       adc_done_flag_i = flags[47];

  vintc_top dut (.*);
  vintc_core_model core (.core_clk_i, .reset_n_i, .fast_request_i(fast_request_o),
    .normal_request_i(normal_request_o), .vector_valid_i(vector_valid_o),
    .vector_data_i(vector_data_o), .vector_read_o(vector_read_i), .last_vector_o(last_vector));

  // ==========================================================
  // Helpers
  function automatic int ch_of(input int b);
    if (b < 3) return (b == 0) ? 0 : b + 1;
    if (b < 19) return (b < 11) ? 4 : 5;
    if (b < 28) return (b < 23) ? 6 : 7;
    if (b < 36) return (b < 35) ? 8 : 9;
    if (b < 41) return (b < 38) ? 10 : ((b < 40) ? 11 : 12);
    if (b < 43) return 13;
    return (b < 47) ? b - 29 : 18;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_map();
    @(posedge core_clk_i);
    int_enable_i <= '1;
    for (int b = 0; b < 48; b++) begin
      flags <= 48'h1 << b;
      step(2);
      check("normal status", 32'h1 << ch_of(b), 32'(normal_status_o));
      check("normal request", 32'h1, normal_request_o);
      check("fast request", 32'h0, fast_request_o);
      @(posedge core_clk_i);
    end
    flags <= '0;
  endtask
  task automatic t_fast();
    @(posedge core_clk_i);
    int_enable_i <= 19'h0_0051;
    fast_select_i <= 19'h0_0111;
    slot_enable_i <= 16'h0004;
    slot_channel_i <= 80'h4 << 10;
    flags <= 48'h1 | (48'h1 << 7) | (48'h1 << 28);
    step(2);
    check("fast request", 32'h1, fast_request_o);
    check("fast status", 32'h11, 32'(fast_status_o));
    check("raw status", 32'h111, 32'(raw_status_o));
    check("normal request", 32'h0, normal_request_o);
    check("vector hit", 32'h0, vector_hit_o);
    @(posedge core_clk_i);
    fast_select_i <= 19'h0_0001;
    step(2);
    check("normal status", 32'h10, 32'(normal_status_o));
    check("vector slot", 32'h2, vector_slot_o);
    @(posedge core_clk_i);
    flags <= '0;
  endtask
  task automatic t_prio();
    @(posedge core_clk_i);
    int_enable_i <= 19'h1_c200;
    fast_select_i <= '0;
    slot_enable_i <= 16'h8221;
    slot_channel_i <= 80'hf | (80'he << 25) | (80'he << 45) | (80'h10 << 75);
    flags <= (48'h1 << 43) | (48'h1 << 45);
    step(4);
    check("slot status", 32'h8220, 32'(slot_status_o));
    check("vector address", 32'h0000_a050, vector_addr_o);
    check("fetched vector", 32'h0000_a050, last_vector);
    @(posedge core_clk_i);
    flags <= (48'h1 << 43) | (48'h1 << 44) | (48'h1 << 45);
    step(4);
    check("vector slot", 32'h0, vector_slot_o);
    check("fetched vector", 32'h0000_a000, last_vector);
    @(posedge core_clk_i);
    flags <= 48'h1 << 35;
    step(4);
    check("normal status", 32'h200, 32'(normal_status_o));
    check("normal request", 32'h1, normal_request_o);
    check("fetched vector", 32'h0000_d000, last_vector);
    @(posedge core_clk_i);
    flags <= '0;
  endtask
  task automatic t_soft();
    @(posedge core_clk_i);
    int_enable_i <= 19'h0_0002;
    slot_enable_i <= 16'h0001;
    slot_channel_i <= 80'h1;
    soft_set_i <= 19'h0_0002;
    @(posedge core_clk_i);
    soft_set_i <= '0;
    #1;
    check("soft pending", 32'h2, 32'(soft_pending_o));
    check("raw status", 32'h0, 32'(raw_status_o));
    step(4);
    check("raw status", 32'h2, 32'(raw_status_o));
    check("fetched vector", 32'h0000_a000, last_vector);
    @(posedge core_clk_i);
    soft_clear_i <= 19'h0_0002;
    @(posedge core_clk_i);
    soft_clear_i <= '0;
    step(1);
    check("normal request", 32'h0, normal_request_o);
    check("soft pending", 32'h0, 32'(soft_pending_o));
  endtask

  // ==========================================================
  // Clock, reset, sequence and timeout
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {reset_n_i, flags, soft_set_i, soft_clear_i, int_enable_i, fast_select_i} = '0;
    {slot_enable_i, slot_channel_i} = '0;
    default_addr_i = 32'h0000_d000;
    for (int s = 0; s < NUM_SLOTS; s++) slot_addr_i[s*ADDR_W +: ADDR_W] = 32'h0000_a000 + s * 16;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_map();
    t_fast();
    t_prio();
    t_soft();
    results();
  end
endmodule // vintc_top_test

bind vintc_top vintc_monitor u_mon (.*);
